// ---- arb_cfg_regs.sv ----
// AHB-Lite slave holding the arbitration weights and sram latency ceiling
// assumes zero-wait single word transfers; response is always OKAY
`default_nettype none

module arb_cfg_regs
    import arb_pkg::*;
(
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [ADDR_W-1:0]   haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output var  logic                hreadyout,
    output var  logic                hresp,
    output var  logic [31:0]         hrdata,
    input  wire logic [31:0]         owner_status,
    output var  logic [WEIGHT_W-1:0] weight_fast_dma,
    output var  logic [WEIGHT_W-1:0] weight_fabric_a,
    output var  logic [WEIGHT_W-1:0] weight_fabric_b,
    output var  logic [WEIGHT_W-1:0] weight_periph_dma,
    output var  logic [LAT_W-1:0]    sram_latency_ceiling
);
    logic              dph_wr_r;
    logic [ADDR_W-1:0] dph_addr_r;
    logic [WEIGHT_W-1:0] w_fast_nxt, w_fab_a_nxt, w_fab_b_nxt, w_per_nxt;
    logic [LAT_W-1:0]  lat_nxt;

    // hsize is not checked: only whole words are mapped
    wire addr_ok = hsel && hready && htrans[1];
    wire wr_a = dph_wr_r && (dph_addr_r == OFF_WEIGHT_A);
    wire wr_b = dph_wr_r && (dph_addr_r == OFF_WEIGHT_B);
    wire wr_l = dph_wr_r && (dph_addr_r == OFF_LAT);
    wire [LAT_W-1:0] lat_wd = hwdata[LAT_W-1:0];
    // ceiling is clamped into one to eight transfers
    wire lat_low = (lat_wd < LAT_MIN) || (hwdata[31:LAT_W] != 28'h0000000);
    wire [LAT_W-1:0] lat_cl = lat_low ? ((lat_wd < LAT_MIN) && (hwdata[31:LAT_W] == 28'h0000000) ? LAT_MIN : LAT_MAX)
                                      : ((lat_wd > LAT_MAX) ? LAT_MAX : lat_wd);

    assign w_fast_nxt  = wr_a ? hwdata[WLO_POS +: WEIGHT_W] : weight_fast_dma;
    assign w_fab_a_nxt = wr_a ? hwdata[WHI_POS +: WEIGHT_W] : weight_fabric_a;
    assign w_fab_b_nxt = wr_b ? hwdata[WLO_POS +: WEIGHT_W] : weight_fabric_b;
    assign w_per_nxt   = wr_b ? hwdata[WHI_POS +: WEIGHT_W] : weight_periph_dma;
    assign lat_nxt     = wr_l ? lat_cl : sram_latency_ceiling;

    // read mux looks at next values so a read right after a write sees it
    wire [31:0] rd_a = {19'h0, w_fab_a_nxt, 3'h0, w_fast_nxt};
    wire [31:0] rd_b = {19'h0, w_per_nxt, 3'h0, w_fab_b_nxt};
    wire [31:0] rd_l = {28'h0000000, lat_nxt};
    wire [31:0] rd_mux = (haddr == OFF_WEIGHT_A) ? rd_a :
                         (haddr == OFF_WEIGHT_B) ? rd_b :
                         (haddr == OFF_LAT)      ? rd_l :
                         (haddr == OFF_OWNER)    ? owner_status : 32'h00000000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_wr_r   <= 1'b0;
            dph_addr_r <= '0;
            hrdata     <= 32'h00000000;
        end else begin
            dph_wr_r   <= addr_ok && hwrite;
            dph_addr_r <= haddr;
            if (addr_ok && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            weight_fast_dma      <= WEIGHT_RST;
            weight_fabric_a      <= WEIGHT_RST;
            weight_fabric_b      <= WEIGHT_RST;
            weight_periph_dma    <= WEIGHT_RST;
            sram_latency_ceiling <= LAT_RST;
            hreadyout            <= 1'b1;
            hresp                <= 1'b0;
        end else begin
            weight_fast_dma      <= w_fast_nxt;
            weight_fabric_a      <= w_fab_a_nxt;
            weight_fabric_b      <= w_fab_b_nxt;
            weight_periph_dma    <= w_per_nxt;
            sram_latency_ceiling <= lat_nxt;
            hreadyout            <= 1'b1;
            hresp                <= 1'b0;
        end
    end
endmodule // arb_cfg_regs

`default_nettype wire

// ---- arb_pkg.sv ----
// constants shared by the slave-port arbiters and their config registers
// assumes one AHB-Lite clock domain, word-only register accesses
`default_nettype none

package arb_pkg;
    localparam int NUM_WRR = 4;
    localparam int WEIGHT_W = 5;
    localparam int LAT_W = 4;
    localparam int OWNER_W = 4;
    localparam int ADDR_W = 8;
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_WEIGHT_A = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_WEIGHT_B = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_LAT = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_OWNER = 8'h0C;
    // field positions inside the weight registers
    localparam int WLO_POS = 0;
    localparam int WHI_POS = 8;
    // values after reset: pure round robin
    localparam logic [WEIGHT_W-1:0] WEIGHT_RST = 5'h01;
    localparam logic [LAT_W-1:0] LAT_RST = 4'h1;
    localparam logic [LAT_W-1:0] LAT_MIN = 4'h1;
    localparam logic [LAT_W-1:0] LAT_MAX = 4'h8;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    typedef enum logic [1:0] {OWN_NONE, OWN_FIXED, OWN_WRR} own_kind_t;
endpackage

`default_nettype wire

// ---- arb_props.sv ----
// grant checker for the slave-port arbiters
// assumes the default port map: ports 0 and 1 are sram
`default_nettype none

module arb_props #(
    parameter int NUM_PORTS = 7
) (
    input wire logic                 hclk,
    input wire logic                 hresetn,
    input wire logic [NUM_PORTS-1:0] slave_ready,
    input wire logic [NUM_PORTS-1:0] system_control_req,
    input wire logic [NUM_PORTS-1:0] fast_dma_req,
    input wire logic [NUM_PORTS-1:0] fast_dma_lock,
    input wire logic [NUM_PORTS-1:0] periph_dma_req,
    input wire logic [NUM_PORTS-1:0] system_control_grant,
    input wire logic [NUM_PORTS-1:0] fast_dma_grant,
    input wire logic [NUM_PORTS-1:0] fabric_if_a_grant,
    input wire logic [NUM_PORTS-1:0] fabric_if_b_grant,
    input wire logic [NUM_PORTS-1:0] periph_dma_grant
);
    timeunit 1ns;
    timeprecision 100ps;
    wire logic [4:0] g0;
    wire logic [4:0] g4;
    assign g0 = {system_control_grant[0], fast_dma_grant[0], fabric_if_a_grant[0], fabric_if_b_grant[0],
                 periph_dma_grant[0]};
    assign g4 = {system_control_grant[4], fast_dma_grant[4], fabric_if_a_grant[4], fabric_if_b_grant[4],
                 periph_dma_grant[4]};
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    one_owner_a: assert property ($onehot0(g0))
        else $error("port 0 has two owners");
    frozen_grant_a: assert property (!slave_ready[4] |=> $stable(g4))
        else $error("grant moved while slave not ready");
    fixed_first_a: assert property (slave_ready[0] && system_control_req[0] && g0[3:0] == 4'h0
        |=> system_control_grant[0])
        else $error("fixed master not granted");
    fixed_cause_a: assert property ($rose(system_control_grant[0]) |-> $past(system_control_req[0]))
        else $error("fixed grant without request");
    fast_cause_a: assert property ($rose(fast_dma_grant[1]) |-> $past(fast_dma_req[1]))
        else $error("fast dma grant without request");
    periph_cause_a: assert property ($rose(periph_dma_grant[0]) |-> $past(periph_dma_req[0]))
        else $error("periph dma grant without request");
    lock_hold_a: assert property (fast_dma_grant[3] && fast_dma_req[3] && fast_dma_lock[3] && slave_ready[3]
        |=> fast_dma_grant[3])
        else $error("locked owner lost grant");
    fixed_release_a: assert property (system_control_grant[1] && slave_ready[1] && !system_control_req[1]
        |=> !system_control_grant[1])
        else $error("fixed master kept idle slave");
endmodule // arb_props

bind matrix_slave_arbiter arb_props #(.NUM_PORTS(NUM_PORTS)) u_arb_props (.hclk, .hresetn, .slave_ready,
    .system_control_req, .fast_dma_req, .fast_dma_lock, .periph_dma_req, .system_control_grant,
    .fast_dma_grant, .fabric_if_a_grant, .fabric_if_b_grant, .periph_dma_grant);

`default_nettype wire

// ---- arb_slave_model.sv ----
// slave side model: per-port ready, stretched by wait states on demand
// assumes the bench raises stall after a clock edge
`default_nettype none

module arb_slave_model #(
    parameter int NUM_PORTS = 7
) (
    input  wire logic [NUM_PORTS-1:0] stall,
    output var  logic [NUM_PORTS-1:0] slave_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    // no data path: only the transfer boundary matters to the arbiter
    assign slave_ready = ~stall;
endmodule // arb_slave_model

`default_nettype wire

// ---- matrix_slave_arbiter.sv ----
// per-slave-port arbiters of a combinational AHB-Lite matrix, plus config regs
// assumes per-port request and lock levels from the master stages and the
// slave's hready per port; grants are one-hot per port and registered
// How it works
// - every slave port has its own arbiter, deciding independently.
// - a running round robin turn is checked before the fixed master; new round robin only when it is idle.
// - system control master is fixed; four DMA and fabric masters share round robin.
// - sram latency ceiling is programmable from one to eight transfers.
// - ceiling cuts a round robin owner only when the fixed master wants sram.
// - each round robin master has a 5-bit transfer weight.
// - after reset all weights and the ceiling are one.
// - same weights on every port; weight one gives one transfer per turn.
// - a locked sequence keeps its master granted until the lock drops.
// - fixed master may displace the next round robin master, which keeps its turn.
// - round robin order is fast dma, fabric a, fabric b, peripheral dma.
// - round robin masters stall while fixed master holds the slave, then resume in order.
// - round robin owner makes weight transfers, then the pointer advances.
// - sram ports cut at min of weight and ceiling while the fixed master requests; others complete full weight.
`default_nettype none

module matrix_slave_arbiter
    import arb_pkg::*;
#(
    parameter int                   NUM_PORTS  = 7,
    parameter logic [NUM_PORTS-1:0] SRAM_PORTS = 7'h03
) (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 hsel,
    input  wire logic [ADDR_W-1:0]    haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output var  logic                 hreadyout,
    output var  logic                 hresp,
    output var  logic [31:0]          hrdata,
    input  wire logic [NUM_PORTS-1:0] slave_ready,
    input  wire logic [NUM_PORTS-1:0] system_control_req,
    input  wire logic [NUM_PORTS-1:0] system_control_lock,
    input  wire logic [NUM_PORTS-1:0] fast_dma_req,
    input  wire logic [NUM_PORTS-1:0] fast_dma_lock,
    input  wire logic [NUM_PORTS-1:0] fabric_if_a_req,
    input  wire logic [NUM_PORTS-1:0] fabric_if_a_lock,
    input  wire logic [NUM_PORTS-1:0] fabric_if_b_req,
    input  wire logic [NUM_PORTS-1:0] fabric_if_b_lock,
    input  wire logic [NUM_PORTS-1:0] periph_dma_req,
    input  wire logic [NUM_PORTS-1:0] periph_dma_lock,
    output var  logic [NUM_PORTS-1:0] system_control_grant,
    output var  logic [NUM_PORTS-1:0] fast_dma_grant,
    output var  logic [NUM_PORTS-1:0] fabric_if_a_grant,
    output var  logic [NUM_PORTS-1:0] fabric_if_b_grant,
    output var  logic [NUM_PORTS-1:0] periph_dma_grant
);
    logic [WEIGHT_W-1:0] weight [NUM_WRR];
    logic [LAT_W-1:0]    lat_ceiling;
    logic [31:0]         owner_status;
    logic [NUM_PORTS*OWNER_W-1:0] owner_flat;

    // owner of each port for software: {kind, wrr index} per nibble
    always_comb begin
        owner_status = 32'h00000000;
        for (int i = 0; i < NUM_PORTS && i < 8; i++) begin
            owner_status[i*OWNER_W +: OWNER_W] = owner_flat[i*OWNER_W +: OWNER_W];
        end
    end

    arb_cfg_regs u_regs (
        .hclk                 (hclk),
        .hresetn              (hresetn),
        .hsel                 (hsel),
        .haddr                (haddr),
        .htrans               (htrans),
        .hwrite               (hwrite),
        .hsize                (hsize),
        .hwdata               (hwdata),
        .hready               (hready),
        .hreadyout            (hreadyout),
        .hresp                (hresp),
        .hrdata               (hrdata),
        .owner_status         (owner_status),
        .weight_fast_dma      (weight[0]),
        .weight_fabric_a      (weight[1]),
        .weight_fabric_b      (weight[2]),
        .weight_periph_dma    (weight[3]),
        .sram_latency_ceiling (lat_ceiling)
    );

    // first requesting wrr master at or after start, wrapping round
    function automatic logic [2:0] pick_wrr(input logic [NUM_WRR-1:0] req, input logic [1:0] start);
        logic [2:0] res;
        logic [1:0] cand;
        res = 3'h0;
        for (int k = NUM_WRR - 1; k >= 0; k--) begin
            cand = start + 2'(k);
            if (req[cand]) begin
                res = {1'b1, cand};
            end
        end
        return res;
    endfunction

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        own_kind_t           kind_r, kind_nxt;
        logic [1:0]          idx_r, idx_nxt;
        logic [1:0]          ptr_r, ptr_nxt;
        logic [WEIGHT_W-1:0] cnt_r, cnt_nxt;
        logic [4:0]          grant_r, grant_nxt;

        // wrr slot order: fast dma, fabric a, fabric b, peripheral dma
        wire [NUM_WRR-1:0] wrr_req  = {periph_dma_req[p], fabric_if_b_req[p],
                                       fabric_if_a_req[p], fast_dma_req[p]};
        wire [NUM_WRR-1:0] wrr_lock = {periph_dma_lock[p], fabric_if_b_lock[p],
                                       fabric_if_a_lock[p], fast_dma_lock[p]};
        wire sys_req  = system_control_req[p];
        wire sys_lock = system_control_lock[p];

        // a weight of zero is served as one transfer
        wire [WEIGHT_W-1:0] w_cur = weight[idx_r];
        wire [WEIGHT_W-1:0] w_lim = (w_cur == 5'h00) ? 5'h01 : w_cur;
        wire [WEIGHT_W-1:0] lat5  = {1'b0, lat_ceiling};
        // ceiling only counts when the fixed master is aiming at an sram port
        wire ceil_on = SRAM_PORTS[p] && sys_req;
        wire [WEIGHT_W-1:0] lim = (ceil_on && (lat5 < w_lim)) ? lat5 : w_lim;
        wire [WEIGHT_W-1:0] done = cnt_r + 5'h01;

        wire wrr_live   = (kind_r == OWN_WRR) && wrr_req[idx_r];
        wire wrr_locked = wrr_live && wrr_lock[idx_r];
        wire sys_locked = (kind_r == OWN_FIXED) && sys_req && sys_lock;
        wire wrr_keep   = wrr_locked || (wrr_live && (done < lim));
        // cut short by the ceiling: it keeps its turn for later
        wire wrr_cut    = wrr_live && !wrr_keep && (done < w_lim);
        wire [1:0] ptr_adv = ((kind_r == OWN_WRR) && !wrr_cut) ? idx_r + 2'h1 : ptr_r;
        wire [2:0] pick = pick_wrr(wrr_req, ptr_adv);

        always_comb begin
            kind_nxt = kind_r;
            idx_nxt  = idx_r;
            ptr_nxt  = ptr_r;
            cnt_nxt  = cnt_r;
            if (sys_locked) begin
                cnt_nxt = 5'h00;
            end else if (wrr_keep) begin
                // locked beats are not charged to the weight
                cnt_nxt = wrr_locked ? cnt_r : done;
            end else if (sys_req) begin
                kind_nxt = OWN_FIXED;
                ptr_nxt  = ptr_adv;
                cnt_nxt  = 5'h00;
            end else if (pick[2]) begin
                kind_nxt = OWN_WRR;
                idx_nxt  = pick[1:0];
                ptr_nxt  = pick[1:0];
                cnt_nxt  = 5'h00;
            end else begin
                kind_nxt = OWN_NONE;
                ptr_nxt  = ptr_adv;
                cnt_nxt  = 5'h00;
            end
        end

        always_comb begin
            grant_nxt = 5'h00;
            unique case (kind_nxt)
                OWN_FIXED: grant_nxt[0] = 1'b1;
                OWN_WRR:   grant_nxt[3'(idx_nxt) + 3'h1] = 1'b1;
                OWN_NONE:  grant_nxt = 5'h00;
            endcase
        end

        // the whole decision moves only on a ready slave: no data phase is cut
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                kind_r  <= OWN_NONE;
                idx_r   <= 2'h0;
                ptr_r   <= 2'h0;
                cnt_r   <= 5'h00;
                grant_r <= 5'h00;
            end else if (slave_ready[p]) begin
                kind_r  <= kind_nxt;
                idx_r   <= idx_nxt;
                ptr_r   <= ptr_nxt;
                cnt_r   <= cnt_nxt;
                grant_r <= grant_nxt;
            end
        end

        assign system_control_grant[p] = grant_r[0];
        assign fast_dma_grant[p]       = grant_r[1];
        assign fabric_if_a_grant[p]    = grant_r[2];
        assign fabric_if_b_grant[p]    = grant_r[3];
        assign periph_dma_grant[p]     = grant_r[4];
        assign owner_flat[p*OWNER_W +: OWNER_W] = {kind_r, idx_r};
    end
endmodule // matrix_slave_arbiter

`default_nettype wire

// ---- tb_top.sv ----
// bench for the slave-port arbiters and their config registers
// assumes default parameters: ports 0 and 1 sram
`default_nettype none

module tb_top
    import arb_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [4:0] SC = 5'h10, FD = 5'h08, FA = 5'h04, FB = 5'h02, PD = 5'h01;
    logic              hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hresp;
    logic [ADDR_W-1:0] haddr = 8'h00;
    logic [1:0]        htrans = 2'h0;
    logic [31:0]       hwdata = 32'h0, hrdata;
    logic [6:0]        sc_req = 7'h00, fd_req = 7'h00, fa_req = 7'h00, fb_req = 7'h00, pd_req = 7'h00;
    logic [6:0]        fd_lock = 7'h00, pd_lock = 7'h00, stall = 7'h00, slave_ready, sc_g, fd_g, fa_g, fb_g, pd_g;
    int                miscompares = 0, num_checks = 0, cycles = 0;

    matrix_slave_arbiter u_matrix_slave_arbiter (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready, .hreadyout(hready), .hresp, .hrdata, .slave_ready,
        .system_control_req(sc_req), .system_control_lock(7'h00), .fast_dma_req(fd_req),
        .fast_dma_lock(fd_lock), .fabric_if_a_req(fa_req), .fabric_if_a_lock(7'h00),
        .fabric_if_b_req(fb_req), .fabric_if_b_lock(7'h00), .periph_dma_req(pd_req),
        .periph_dma_lock(pd_lock), .system_control_grant(sc_g), .fast_dma_grant(fd_g),
        .fabric_if_a_grant(fa_g), .fabric_if_b_grant(fb_g), .periph_dma_grant(pd_g));
    arb_slave_model u_arb_slave_model (.stall, .slave_ready);

    initial begin
        forever #5 hclk = ~hclk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge hclk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [4:0] own(input int p);
        return {sc_g[p], fd_g[p], fa_g[p], fb_g[p], pd_g[p]};
    endfunction

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        chk(r, e);
        // zero-wait, always OKAY
        chk({30'h0, hready, hresp}, 32'h0000_0002);
    endtask

    // sc bit k is the fixed master's request in cycle k; ex[k] the owner after edge k+1
    task automatic seq(input int p, input int n, input logic [16:0] sc, input logic [4:0] ex [16]);
        sc_req[p] <= sc[0];
        for (int k = 0; k < n; k++) begin
            @(posedge hclk);
            sc_req[p] <= sc[k+1];
            #1 chk({27'h0, own(p)}, {27'h0, ex[k]});
        end
        @(posedge hclk);
    endtask

    task automatic clr();
        @(posedge hclk);
        {sc_req, fd_req, fa_req, fb_req, pd_req, fd_lock, pd_lock, stall} <= 56'h0;
        @(posedge hclk);
    endtask

    initial begin
        logic [31:0] r;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk(OFF_WEIGHT_A, 32'h0000_0101);
        rd_chk(OFF_WEIGHT_B, 32'h0000_0101);
        rd_chk(OFF_LAT, 32'h0000_0001);
        rd_chk(OFF_OWNER, 32'h0000_0000);
        ahb(1'b1, 8'h10, 32'hFFFF_FFFF, r);
        rd_chk(8'h10, 32'h0000_0000);
        ahb(1'b1, OFF_LAT, 32'h0000_000F, r);
        rd_chk(OFF_LAT, 32'h0000_0008);
        ahb(1'b1, OFF_LAT, 32'h0000_0000, r);
        rd_chk(OFF_LAT, 32'h0000_0001);
        $display("test regs done");
        {fd_req[1], fa_req[1], fb_req[1], pd_req[1]} <= 4'hF;
        seq(1, 6, 17'h0000A, '{0: FD, 1: SC, 2: FA, 3: SC, 4: FB, 5: PD, default: 5'h00});
        clr();
        $display("test pure round robin done");
        ahb(1'b1, OFF_WEIGHT_B, 32'h0000_0108, r);
        fb_req[2] <= 1'b1;
        seq(2, 16, 17'h00FFE, '{8: SC, 9: SC, 10: SC, 11: SC, default: FB});
        clr();
        $display("test weight done");
        ahb(1'b1, OFF_WEIGHT_B, 32'h0000_0801, r);
        ahb(1'b1, OFF_LAT, 32'h0000_0004, r);
        rd_chk(OFF_LAT, 32'h0000_0004);
        pd_req[0] <= 1'b1;
        seq(0, 12, 17'h000FE, '{4: SC, 5: SC, 6: SC, 7: SC, default: PD});
        clr();
        $display("test sram ceiling done");
        // port 0 holds a locked periph dma too: the sram ceiling must not cut it
        {fd_req[3], fd_lock[3], pd_req[0], pd_lock[0]} <= 4'hF;
        @(posedge hclk);
        sc_req[0] <= 1'b1;
        @(posedge hclk);
        seq(3, 6, 17'h1FFFF, '{default: FD});
        #1 chk({27'h0, own(0)}, {27'h0, PD});
        @(posedge hclk);
        {fd_req[3], fd_lock[3], pd_req[0], pd_lock[0]} <= 4'h0;
        @(posedge hclk);
        #1 chk({27'h0, own(3)}, {27'h0, SC});
        chk({27'h0, own(0)}, {27'h0, SC});
        clr();
        $display("test lock done");
        {fd_req[4], fa_req[4], fa_req[5], fb_req[6]} <= 4'hF;
        for (int k = 0; k < 4; k++) begin
            @(posedge hclk);
            stall[4] <= (k < 3);
            #1 chk({27'h0, own(4)}, {27'h0, FD});
        end
        @(posedge hclk);
        #1 chk({27'h0, own(4)}, {27'h0, FA});
        chk({27'h0, own(5)}, {27'h0, FA});
        chk({27'h0, own(6)}, {27'h0, FB});
        clr();
        $display("test stall done");
        // reset again mid-run: registers and owner state must return to defaults
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk(OFF_WEIGHT_B, 32'h0000_0101);
        rd_chk(OFF_LAT, 32'h0000_0001);
        rd_chk(OFF_OWNER, 32'h0000_0000);
        $display("test mid-run reset done");
        give_verdict();
    end
endmodule // tb_top

`default_nettype wire
